// >>> hw/sbit_pkg.sv
/*
 * Shared constants and types of the sixteen-bit interval timer: register
 * offsets, control field positions, reset values and prescale ratios.
 * Assumes a 32-bit APB slave and a single 100 MHz clock.
 */
package sbit_pkg;

    localparam int unsigned CNT_W       = 16;
    localparam int unsigned APB_AW      = 12;
    localparam int unsigned SYNC_STAGES = 2;

    // Byte addresses of the register words.
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_COUNT  = 12'h004;
    localparam logic [11:0] OFF_PERIOD = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;

    // Control register field positions.
    localparam int unsigned BIT_RUN   = 15;
    localparam int unsigned BIT_IDLE  = 13;
    localparam int unsigned BIT_GATE  = 6;
    localparam int unsigned BIT_PS_HI = 5;
    localparam int unsigned BIT_PS_LO = 4;
    localparam int unsigned BIT_SYNC  = 2;
    localparam int unsigned BIT_CS    = 1;
    localparam int unsigned BIT_FLAG  = 0;

    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] CTRL_MASK    = 16'hA076;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // Prescale select codes and the ratios they give.
    localparam logic [1:0] PS_CODE_1   = 2'h0;
    localparam logic [1:0] PS_CODE_8   = 2'h1;
    localparam logic [1:0] PS_CODE_64  = 2'h2;
    localparam logic [1:0] PS_CODE_256 = 2'h3;
    localparam int unsigned PS_DIV_1   = 1;
    localparam int unsigned PS_DIV_8   = 8;
    localparam int unsigned PS_DIV_64  = 64;
    localparam int unsigned PS_DIV_256 = 256;

    typedef enum logic [1:0] {
        MODE_TIMER,
        MODE_GATED,
        MODE_SYNC_CNT,
        MODE_ASYNC_CNT
    } sbit_mode_t;

    typedef struct packed {
        logic       timer_run;
        logic       idle_halt;
        logic       gate_accumulate_enable;
        logic [1:0] prescale_select;
        logic       ext_clock_sync_select;
        logic       clock_source_select;
    } sbit_ctrl_t;

endpackage : sbit_pkg

// >>> hw/sbit_prescaler.sv
/*
 * Count-clock prescaler: passes every first, eighth, 64th or 256th input
 * tick. Assumes ticks are one-cycle pulses in the CLK domain.
 */
`timescale 1ns/1ps
module sbit_prescaler #(
    parameter int unsigned MAX_DIV = sbit_pkg::PS_DIV_256
) (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       clear,
    // Ticks
    input  wire logic       tick_in,
    input  wire logic [1:0] sel,
    output logic            tick_out,
    output logic            toggle_out
);
    localparam int unsigned PW = $clog2(MAX_DIV);

    initial begin
        if (MAX_DIV < sbit_pkg::PS_DIV_256) begin
            $error("sbit_prescaler: MAX_DIV must be at least 256");
        end
    end

    logic [PW-1:0] cnt_q;
    logic [PW-1:0] cnt_d;
    logic [PW-1:0] term;
    logic          wrap;

    assign term = (sel == sbit_pkg::PS_CODE_256) ? PW'(sbit_pkg::PS_DIV_256 - 1) :
                  (sel == sbit_pkg::PS_CODE_64)  ? PW'(sbit_pkg::PS_DIV_64 - 1)  :
                  (sel == sbit_pkg::PS_CODE_8)   ? PW'(sbit_pkg::PS_DIV_8 - 1)   :
                                                   PW'(sbit_pkg::PS_DIV_1 - 1);
    assign wrap  = tick_in && (cnt_q >= term);
    assign cnt_d = clear ? '0 : wrap ? '0 : tick_in ? cnt_q + 1'b1 : cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q      <= '0;
            tick_out   <= 1'b0;
            toggle_out <= 1'b0;
        end else if (ce) begin
            cnt_q      <= cnt_d;
            tick_out   <= wrap && !clear;
            toggle_out <= toggle_out ^ (wrap && !clear);
        end
    end

endmodule : sbit_prescaler

// >>> hw/sbit_tick_sync.sv
/*
 * Carries a toggling prescaler output through a flip-flop chain and turns
 * each toggle into a one-cycle pulse. Assumes a single clock domain.
 */
`timescale 1ns/1ps
module sbit_tick_sync #(
    parameter int unsigned STAGES = sbit_pkg::SYNC_STAGES
) (
    // Clock and control
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    // Toggle in, pulse out
    input  wire logic toggle_in,
    output logic      pulse_out
);
    initial begin
        if (STAGES < 2) begin
            $error("sbit_tick_sync: STAGES must be at least 2");
        end
    end

    logic [STAGES:0] chain_q;

    // Only the last pair is compared; the first stage feeds the next alone.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chain_q   <= '0;
            pulse_out <= 1'b0;
        end else if (ce) begin
            chain_q   <= {chain_q[STAGES-1:0], toggle_in};
            pulse_out <= chain_q[STAGES] ^ chain_q[STAGES-1];
        end
    end

endmodule : sbit_tick_sync

// >>> hw/sbit_timer.sv
/*
 * Sixteen-bit interval timer with APB register access: control, count,
 * period and status words. Assumes APB signals and the external count pin
 * are synchronous to CLK, and that IDLE_MODE and SLEEP_MODE come from the
 * chip power manager as levels.
 */
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps

// Behaviour
// - A 16-bit counter serves as real-time clock base or interval timer.
// - Four modes: timer, gated timer, synchronous and asynchronous counter.
// - Timer and gated timer modes count the internal instruction clock.
// - Both counter modes count the external count clock pin.
// - Source, gate and sync bits together pick one of the four modes.
// - Source select at bit 1, sync select bit 2, gate enable bit 6.
// - Synchronised external counting is synchronised after the prescaler.
// - Unsynchronised external counting keeps running without internal clock.
// - Idle-halt bit 13 stops the module during Idle when set.
// - Gate bit matters only with the internal source selected.
// - Prescale bits 5-4 divide the count clock by 1, 8, 64 or 256.
// - Sync bit chooses synchronised external clock; ignored with internal.
// - Source select one counts rising pin edges, zero the internal clock.
// - Control bits 14, 12-7, 3 and 0 always read as zero.
module sbit_timer #(
    parameter int unsigned CNT_WIDTH = sbit_pkg::CNT_W
) (
    // Clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // External count clock or gate
    input  wire logic        EXT_COUNT_CLOCK_PIN,
    // Power states
    input  wire logic        IDLE_MODE,
    input  wire logic        SLEEP_MODE,
    // Timer state
    output logic      [15:0] COUNT_VALUE,
    output logic             PERIOD_MATCH_FLAG
);
    initial begin
        if (CNT_WIDTH != sbit_pkg::CNT_W) begin
            $error("sbit_timer: CNT_WIDTH must be 16");
        end
    end

    // Register state.
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] period_q;
    logic [15:0] period_d;
    logic        flag_q;
    logic        flag_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        pin_q;

    sbit_pkg::sbit_ctrl_t ctrl;
    sbit_pkg::sbit_mode_t mode;

    // Bus decode.
    wire         apb_setup   = PSEL && !PENABLE;
    wire         apb_access  = PSEL && PENABLE;
    wire         hit_ctrl    = (PADDR == sbit_pkg::OFF_CTRL);
    wire         hit_count   = (PADDR == sbit_pkg::OFF_COUNT);
    wire         hit_period  = (PADDR == sbit_pkg::OFF_PERIOD);
    wire         hit_status  = (PADDR == sbit_pkg::OFF_STATUS);
    wire         mapped      = hit_ctrl || hit_count || hit_period || hit_status;
    wire         wr          = apb_access && PWRITE && mapped;
    wire         wr_ctrl     = wr && hit_ctrl;
    wire         wr_count    = wr && hit_count;
    wire         wr_period   = wr && hit_period;
    wire         wr_status   = wr && hit_status;

    // Merges the written byte lanes into a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge16

    // Control fields.
    assign ctrl.timer_run              = ctrl_q[sbit_pkg::BIT_RUN];
    assign ctrl.idle_halt              = ctrl_q[sbit_pkg::BIT_IDLE];
    assign ctrl.gate_accumulate_enable = ctrl_q[sbit_pkg::BIT_GATE];
    assign ctrl.prescale_select        = ctrl_q[sbit_pkg::BIT_PS_HI:sbit_pkg::BIT_PS_LO];
    assign ctrl.ext_clock_sync_select  = ctrl_q[sbit_pkg::BIT_SYNC];
    assign ctrl.clock_source_select    = ctrl_q[sbit_pkg::BIT_CS];

    // Gate is ignored with the external source, sync with the internal one.
    assign mode = ctrl.clock_source_select ?
                  (ctrl.ext_clock_sync_select ? sbit_pkg::MODE_SYNC_CNT
                                              : sbit_pkg::MODE_ASYNC_CNT) :
                  (ctrl.gate_accumulate_enable ? sbit_pkg::MODE_GATED
                                               : sbit_pkg::MODE_TIMER);

    // Run gating. The internal clock stops in sleep, so every mode that
    // leans on it halts; only the unsynchronised counter keeps going.
    wire halt_idle  = ctrl.idle_halt && IDLE_MODE;
    wire halt_sleep = SLEEP_MODE && (mode != sbit_pkg::MODE_ASYNC_CNT);
    wire active     = ctrl.timer_run && !halt_idle && !halt_sleep;

    // Count clock source.
    wire pin_rise = EXT_COUNT_CLOCK_PIN && !pin_q;
    logic src_tick;

    always_comb begin
        src_tick = 1'b0;
        unique case (mode)
            sbit_pkg::MODE_TIMER:     src_tick = 1'b1;
            sbit_pkg::MODE_GATED:     src_tick = EXT_COUNT_CLOCK_PIN;
            sbit_pkg::MODE_SYNC_CNT:  src_tick = pin_rise;
            sbit_pkg::MODE_ASYNC_CNT: src_tick = pin_rise;
        endcase
    end

    wire ps_tick;
    wire ps_toggle;
    wire sync_tick;

    sbit_prescaler #(
        .MAX_DIV    (sbit_pkg::PS_DIV_256)
    ) u_prescaler (
        .clk        (CLK),
        .rst_n      (RST_N),
        .ce         (CE),
        .clear      (!ctrl.timer_run),
        .tick_in    (src_tick && active),
        .sel        (ctrl.prescale_select),
        .tick_out   (ps_tick),
        .toggle_out (ps_toggle)
    );

    // Synchronisation sits behind the prescaler, so it costs latency but
    // not count resolution at high pin rates.
    sbit_tick_sync #(
        .STAGES     (sbit_pkg::SYNC_STAGES)
    ) u_tick_sync (
        .clk        (CLK),
        .rst_n      (RST_N),
        .ce         (CE),
        .toggle_in  (ps_toggle),
        .pulse_out  (sync_tick)
    );

    wire count_tick = ctrl.timer_run &&
                      ((mode == sbit_pkg::MODE_SYNC_CNT) ? sync_tick : ps_tick);
    wire at_period  = (count_q == period_q);

    // Next-state of the registers.
    assign ctrl_d   = wr_ctrl ? (merge16(ctrl_q, PWDATA, PSTRB) & sbit_pkg::CTRL_MASK)
                              : ctrl_q;
    assign period_d = wr_period ? merge16(period_q, PWDATA, PSTRB) : period_q;

    // A software write to the count wins over a tick in the same cycle.
    assign count_d  = wr_count   ? merge16(count_q, PWDATA, PSTRB) :
                      count_tick ? (at_period ? sbit_pkg::COUNT_RESET
                                              : count_q + 16'h0001)
                                 : count_q;

    // Write one to clear; a match in the same cycle keeps the flag set.
    wire flag_set   = count_tick && at_period && !wr_count;
    wire flag_clr   = wr_status && PSTRB[0] && PWDATA[sbit_pkg::BIT_FLAG];
    assign flag_d   = flag_set || (flag_q && !flag_clr);

    // Read data is latched in the setup phase so PRDATA leaves a flop.
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (apb_setup && !PWRITE) begin
            if (hit_ctrl) begin
                rdata_d = {16'h0000, ctrl_q & sbit_pkg::CTRL_MASK};
            end else if (hit_count) begin
                rdata_d = {16'h0000, count_q};
            end else if (hit_period) begin
                rdata_d = {16'h0000, period_q};
            end else if (hit_status) begin
                rdata_d = {31'h0000_0000, flag_q};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_q   <= sbit_pkg::CTRL_RESET;
            count_q  <= sbit_pkg::COUNT_RESET;
            period_q <= sbit_pkg::PERIOD_RESET;
            flag_q   <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            pin_q    <= 1'b0;
        end else if (CE) begin
            ctrl_q   <= ctrl_d;
            count_q  <= count_d;
            period_q <= period_d;
            flag_q   <= flag_d;
            rdata_q  <= rdata_d;
            pin_q    <= EXT_COUNT_CLOCK_PIN;
        end
    end

    // Zero wait states; while CE is low the bus still completes, but state
    // is frozen, so software should not access the block then.
    assign PREADY            = 1'b1;
    assign PSLVERR           = apb_access && !mapped;
    assign PRDATA            = rdata_q;
    assign COUNT_VALUE       = count_q;
    assign PERIOD_MATCH_FLAG = flag_q;

endmodule : sbit_timer

// >>> test/sbit_chk.sv
/* Port-level checker for the interval timer, bound to its top module.
   Assumes one clock domain and that software writes control as a whole word. */
`timescale 1ns/1ps
module sbit_chk #(
    parameter int unsigned CNT_WIDTH = 16
) (
    // Clock and control
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        CE,
    // Register bus
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0]  PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    // Pins and state
    input wire logic        EXT_COUNT_CLOCK_PIN,
    input wire logic        IDLE_MODE,
    input wire logic        SLEEP_MODE,
    input wire logic [15:0] COUNT_VALUE,
    input wire logic        PERIOD_MATCH_FLAG
);
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    logic [15:0] ctl_q;
    logic [2:0]  stp_q;
    wire         wr_acc = PSEL && PENABLE && PWRITE && CE;
    wire         cnt_wr = wr_acc && PADDR == sbit_pkg::OFF_COUNT;
    wire         run    = ctl_q[15];
    wire         frz    = ctl_q[13] && IDLE_MODE;
    wire         div8   = run && ctl_q[6:4] == 3'h1 && !ctl_q[1];
    wire         gated  = run && ctl_q[6] && !ctl_q[1];

    // The mode is not visible at the ports, so the control word is mirrored here.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctl_q <= 16'h0000;
            stp_q <= 3'h0;
        end else begin
            if (wr_acc && PADDR == sbit_pkg::OFF_CTRL) begin
                ctl_q <= PWDATA[15:0];
            end
            stp_q <= (run || cnt_wr) ? 3'h0 : ((stp_q == 3'h7) ? stp_q : stp_q + 3'h1);
        end
    end

    sequence s_tick8;
        div8 && $changed(COUNT_VALUE) && !$past(cnt_wr);
    endsequence
    sequence s_quiet7;
        ($stable(COUNT_VALUE) || $past(cnt_wr) || !div8) [*7];
    endsequence
    sequence s_gate_low;
        (gated && !EXT_COUNT_CLOCK_PIN && !cnt_wr) [*4];
    endsequence

    property p_rsv;
        PSEL && PENABLE && !PWRITE && PADDR == sbit_pkg::OFF_CTRL
            |-> (PRDATA & ~{16'h0000, sbit_pkg::CTRL_MASK}) == 32'h0000_0000;
    endproperty
    property p_cw;
        cnt_wr && PSTRB[1:0] == 2'h3 |=> COUNT_VALUE == $past(PWDATA[15:0]);
    endproperty
    property p_step;
        $changed(COUNT_VALUE) && !$past(cnt_wr)
            |-> COUNT_VALUE == $past(COUNT_VALUE) + 16'h0001 || COUNT_VALUE == 16'h0000;
    endproperty
    property p_flag;
        $rose(PERIOD_MATCH_FLAG) |-> COUNT_VALUE == 16'h0000;
    endproperty
    property p_stop;
        stp_q == 3'h7 |-> $stable(COUNT_VALUE);
    endproperty
    property p_idle;
        frz && $past(frz) && $past(frz, 2) && !$past(cnt_wr) |-> $stable(COUNT_VALUE);
    endproperty
    property p_ps8;
        s_tick8 |=> s_quiet7;
    endproperty
    property p_gate;
        s_gate_low |-> $stable(COUNT_VALUE);
    endproperty

    a_rsv: assert property (p_rsv) else $error("reserved control bit read as one");
    a_cw: assert property (p_cw) else $error("count write not applied");
    a_step: assert property (p_step) else $error("count moved by other than one");
    a_flag: assert property (p_flag) else $error("match flag set off the wrap");
    a_stop: assert property (p_stop) else $error("count moved while stopped");
    a_idle: assert property (p_idle) else $error("count moved in idle halt");
    a_ps8: assert property (p_ps8) else $error("ticks closer than eight");
    a_gate: assert property (p_gate) else $error("count moved with gate low");
endmodule : sbit_chk

// >>> test/sbit_pin_model.sv
/* Source on the external count pin: a square wave while enabled, else a
   static gate level. Assumes it is clocked by the bench clock. */
`timescale 1ns/1ps
module sbit_pin_model (
    // Clock and control
    input  wire logic       clk,
    input  wire logic       en,
    input  wire logic       level,
    input  wire logic [3:0] half,
    // Pin
    output logic            pin
);
    logic [3:0] cnt_q;
    initial begin
        pin = 1'h0;
        cnt_q = 4'h0;
    end
    // Each phase lasts whole cycles, so every rising edge is seen once.
    always @(posedge clk) begin
        if (!en) begin
            pin <= level;
            cnt_q <= 4'h0;
        end else if (cnt_q + 4'h1 >= half) begin
            pin <= !pin;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule : sbit_pin_model

// >>> test/tb_top.sv
/* Self-checking bench for the interval timer: APB master tasks, a pin source
   and scripted plus random scenarios. Assumes a 100 MHz clock. */
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel = 1'h0;
    logic        pen = 1'h0;
    logic        pwr = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin;
    logic        idle = 1'h0;
    logic        sleep = 1'h0;
    logic        ce = 1'h1;
    logic [15:0] cnt;
    logic        flag;
    logic        m_en = 1'h0;
    logic        m_lvl = 1'h0;
    int          failures = 0;
    int          check_count = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    sbit_timer dut (
        .CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EXT_COUNT_CLOCK_PIN(pin), .IDLE_MODE(idle),
        .SLEEP_MODE(sleep), .COUNT_VALUE(cnt), .PERIOD_MATCH_FLAG(flag)
    );
    sbit_pin_model src (.clk(clk), .en(m_en), .level(m_lvl), .half(4'h3), .pin(pin));

    function automatic logic [15:0] ctl_exp(input logic [15:0] d);
        return d & sbit_pkg::CTRL_MASK;
    endfunction : ctl_exp

    function automatic int ps_div(input logic [1:0] code);
        case (code)
            sbit_pkg::PS_CODE_8:   return sbit_pkg::PS_DIV_8;
            sbit_pkg::PS_CODE_64:  return sbit_pkg::PS_DIV_64;
            sbit_pkg::PS_CODE_256: return sbit_pkg::PS_DIV_256;
            default:               return sbit_pkg::PS_DIV_1;
        endcase
    endfunction : ps_div

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= 4'hF;
        @(posedge clk);
        pen <= 1'h1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (n == 20)
            failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask : wr

    task automatic rdc(input string what, input logic [11:0] a, input logic [15:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 16'h0000, r, e);
        chk(what, r, 32'(exp));
    endtask : rdc

    task automatic results;
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [15:0] v;
        v = 16'($urandom(47));
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        rdc("control reset", sbit_pkg::OFF_CTRL, 16'h0000);
        rdc("period reset", sbit_pkg::OFF_PERIOD, sbit_pkg::PERIOD_RESET);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 16'h7FFF : 16'($urandom) & 16'h7FFF;
            wr(sbit_pkg::OFF_CTRL, v);
            rdc("control", sbit_pkg::OFF_CTRL, ctl_exp(v));
            v = 16'($urandom);
            wr(sbit_pkg::OFF_COUNT, v);
            rdc("count", sbit_pkg::OFF_COUNT, v);
        end
        apb(1'h0, 12'h010, 16'h0000, r, e);
        chk("unmapped error", 32'(e), 32'h0000_0001);
        chk("unmapped data", r, 32'h0000_0000);
        wr(sbit_pkg::OFF_CTRL, 16'h0000);
        wr(sbit_pkg::OFF_COUNT, 16'h0000);
        wr(sbit_pkg::OFF_PERIOD, 16'h0002);
        wr(sbit_pkg::OFF_CTRL, 16'h8000);
        for (int k = 1; k <= 4; k++) begin
            @(posedge clk);
            #1;
            chk("walk count", 32'(cnt), 32'((k - 1) % 3));
            chk("walk flag", 32'(flag), 32'(k == 4));
        end
        rdc("status read", sbit_pkg::OFF_STATUS, 16'h0001);
        wr(sbit_pkg::OFF_CTRL, 16'h0000);
        wr(sbit_pkg::OFF_STATUS, 16'h0001);
        #1;
        chk("flag cleared", 32'(flag), 32'h0000_0000);
        wr(sbit_pkg::OFF_PERIOD, 16'hFFFF);
        for (int c = 0; c < 4; c++) begin
            wr(sbit_pkg::OFF_CTRL, 16'h0000);
            wr(sbit_pkg::OFF_COUNT, 16'h0000);
            wr(sbit_pkg::OFF_CTRL, 16'h8000 | 16'(c << 4) | 16'((c % 2) << 2));
            repeat (3 * ps_div(2'(c)) + 1) @(posedge clk);
            #1;
            chk("prescaled count", 32'(cnt), 32'h0000_0003);
        end
        wr(sbit_pkg::OFF_CTRL, 16'hA000);
        idle <= 1'h1;
        repeat (4) @(posedge clk);
        #1;
        v = cnt;
        repeat (20) @(posedge clk);
        #1;
        chk("idle frozen", 32'(cnt), 32'(v));
        wr(sbit_pkg::OFF_CTRL, 16'h8000);
        repeat (5) @(posedge clk);
        #1;
        chk("idle running", 32'(cnt != v), 32'h0000_0001);
        // The timer is running at 1:1 here, so a frozen count proves the enable.
        @(posedge clk);
        ce <= 1'h0;
        repeat (2) @(posedge clk);
        #1;
        v = cnt;
        repeat (8) @(posedge clk);
        #1;
        chk("enable frozen", 32'(cnt), 32'(v));
        @(posedge clk);
        ce <= 1'h1;
        for (int s = 0; s < 2; s++) begin
            wr(sbit_pkg::OFF_CTRL, 16'h0000);
            idle <= 1'h0;
            wr(sbit_pkg::OFF_COUNT, 16'h0000);
            wr(sbit_pkg::OFF_CTRL, (s == 1) ? 16'h8002 : 16'h8046);
            m_en <= 1'h1;
            sleep <= 1'(s);
            repeat (60) @(posedge clk);
            #1;
            chk("edge count", 32'(cnt >= 16'h0008 && cnt <= 16'h000A), 32'h1);
        end
        wr(sbit_pkg::OFF_CTRL, 16'h0000);
        m_en <= 1'h0;
        sleep <= 1'h0;
        wr(sbit_pkg::OFF_COUNT, 16'h0000);
        wr(sbit_pkg::OFF_CTRL, 16'h8040);
        m_lvl <= 1'h1;
        repeat (10) @(posedge clk);
        m_lvl <= 1'h0;
        repeat (20) @(posedge clk);
        #1;
        chk("gated count", 32'(cnt), 32'h0000_000A);
        results();
    end
endmodule : tb_top

bind sbit_timer sbit_chk #(.CNT_WIDTH(CNT_WIDTH)) u_chk (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .EXT_COUNT_CLOCK_PIN(EXT_COUNT_CLOCK_PIN), .IDLE_MODE(IDLE_MODE),
    .SLEEP_MODE(SLEEP_MODE), .COUNT_VALUE(COUNT_VALUE), .PERIOD_MATCH_FLAG(PERIOD_MATCH_FLAG)
);
